// ==== logic/cspc_pin_control.v ====
// Configuration-status pins, init handshake and scan-port handoff
// Functional notes
// - High busy output high until I/O active
// - Low busy output low until I/O active
// - After configuration both become user I/O
// - Init line pulled low during memory clear
// - Init held low externally blocks configuration start
// - Master mode waits extra 30 to 300 us
// - Init driven low on configuration data error
// - Init becomes user I/O once I/O active
// - No retention macro disables scan after configuration
// - Test inputs come straight from pads
// - TAP controller, instruction register, three bits/cell
// - Configuration data may load via scan port
`timescale 1ns/1ps
`include "cspc_regs.vh"
module cspc_pin_control (
    // Clock and reset
    input  wire                       sys_clk,
    input  wire                       reset,
    // Configuration core status
    input  wire                       masterMode,
    input  wire                       cfgDone,
    input  wire                       cfgError,
    input  wire                       scan_retention_macro,
    // Init handshake, open drain (oe low drives)
    input  wire                       initIn,
    output reg                        initOut,
    output reg                        initOe_n,
    // config_busy_high_out pin
    output reg                        config_busy_high_out,
    output reg                        busyHighOe_n,
    // config_busy_low_out pin
    output reg                        config_busy_low_out,
    output reg                        busyLowOe_n,
    // User logic drives for the released pins
    input  wire                       userHighOut,
    input  wire                       userHighOe_n,
    input  wire                       userLowOut,
    input  wire                       userLowOe_n,
    input  wire                       userInitOut,
    input  wire                       userInitOe_n,
    // Test pads, taken straight from the pad
    input  wire                       testClk,
    input  wire                       testMode,
    input  wire                       testDataIn,
    input  wire [`CSPC_IO_CELLS-1:0]  cellIn,
    // Test outputs and status
    output reg                        testDataOut,
    output reg                        scanActive,
    output reg                        padTestClk,
    output reg                        padTestMode,
    output reg                        padTestData,
    output reg                        cfgStart,
    output reg                        ioActive,
    output reg                        scanCfgSelect,
    output reg                        scanCfgBit,
    output reg                        scanCfgValid
);
    // One-hot phases of the power-up sequence
    localparam CLEAR  = 5'b00001;
    localparam WAITI  = 5'b00010;
    localparam EXTRA  = 5'b00100;
    localparam CONFIG = 5'b01000;
    localparam ACTIVE = 5'b10000;
    // Extra-wait target; the 32-bit count is cut to the timer width
    localparam [31:0] WAIT_INT = `CSPC_WAIT_CYCLES;
    localparam [`CSPC_CNT_W-1:0] WAIT_CNT = WAIT_INT[`CSPC_CNT_W-1:0];

    // Sequencer state and its timer
    reg [4:0]              phase;      // Current phase
    reg [4:0]              next_phase; // Next phase
    reg [`CSPC_CNT_W-1:0]  count;      // Clear and wait timer
    reg                    tckLast;    // Previous test clock level
    reg                    scanOn;     // Boundary scan enabled
    // Results from the scan controller
    wire                   tdoTap;     // Serial out of the TAP
    wire                   selTap;     // Scan configuration selected
    wire                   bitTap;     // Scan configuration bit
    wire                   vldTap;     // Scan configuration strobe

    // Sequencer next-phase decode
    always @* begin
        case (phase)
            // memory clear lasts a fixed count
            CLEAR:  next_phase = (count == `CSPC_CLEAR_CYCLES) ? WAITI : CLEAR;
            // wait while any party holds init low
            WAITI:  next_phase = !initIn ? WAITI :
                                 (masterMode ? EXTRA : CONFIG);
            // extra master-mode wait, 30 us at this clock
            // init pulled low again restarts the wait
            EXTRA:  next_phase = !initIn ? WAITI :
                                 ((count == WAIT_CNT) ? CONFIG : EXTRA);
            // Stay until the core reports the load complete
            CONFIG: next_phase = cfgDone ? ACTIVE : CONFIG;
            // Only a reset leaves the released state
            ACTIVE: next_phase = ACTIVE;
            // Stray codes fall back to a fresh memory clear
            default: next_phase = CLEAR;
        endcase
    end

    // Sequencer state and timer; timer restarts on every phase change
    always @(posedge sys_clk) begin
        if (reset) begin
            phase <= CLEAR;
            count <= 16'h0000;
        end else begin
            phase <= next_phase;
            // Each new phase times itself from zero
            if (next_phase != phase)
                count <= 16'h0000;
            // Only the timed phases advance the counter
            else if (phase == CLEAR || phase == EXTRA)
                count <= count + 16'h0001;
        end
    end

    // Trade-off: one cycle of lag on each pin buys glitch-free status
    // Pin drives; all outputs registered so status pins never glitch
    always @(posedge sys_clk) begin
        if (reset) begin
            config_busy_high_out <= 1'b1;
            busyHighOe_n         <= 1'b0;
            config_busy_low_out  <= 1'b0;
            busyLowOe_n          <= 1'b0;
            initOut              <= 1'b0;
            initOe_n             <= 1'b0;
            cfgStart             <= 1'b0;
            ioActive             <= 1'b0;
            scanOn               <= 1'b1;
            scanActive           <= 1'b1;
        end else begin
            // One-cycle pulse on entry to configuration
            cfgStart <= (phase != CONFIG) && (next_phase == CONFIG);
            // Level that follows the release to user logic
            ioActive <= (next_phase == ACTIVE);
            if (next_phase == ACTIVE) begin
                // both busy pins handed to user logic
                config_busy_high_out <= userHighOut;
                busyHighOe_n         <= userHighOe_n;
                config_busy_low_out  <= userLowOut;
                busyLowOe_n          <= userLowOe_n;
                initOut              <= userInitOut;
                initOe_n             <= userInitOe_n;
            end else begin
                config_busy_high_out <= 1'b1;
                busyHighOe_n         <= 1'b0;
                config_busy_low_out  <= 1'b0;
                busyLowOe_n          <= 1'b0;
                initOut              <= 1'b0;
                // pull init low in clear or on error
                if (next_phase == CLEAR)
                    initOe_n <= 1'b0;
                else if (phase == CONFIG && cfgError)
                    initOe_n <= 1'b0;
                // An error report stands until release
                else if (phase == CONFIG)
                    initOe_n <= initOe_n;
                // Released to the pull-up while waiting
                else
                    initOe_n <= 1'b1;
            end
            // Macro choice latched once, on entry to release
            // scan stays on only with retention macro
            if (next_phase == ACTIVE && phase != ACTIVE)
                scanOn <= scan_retention_macro;
            scanActive <= (next_phase == ACTIVE && phase != ACTIVE) ?
                          scan_retention_macro : scanOn;
        end
    end

    // test pads feed internal logic directly at any time
    always @(posedge sys_clk) begin
        if (reset) begin
            tckLast     <= 1'b0;
            padTestClk  <= 1'b0;
            padTestMode <= 1'b1;
            padTestData <= 1'b0;
        end else begin
            // Sampled every cycle, whatever the scan state
            tckLast     <= testClk;
            padTestClk  <= testClk;
            padTestMode <= testMode;
            padTestData <= testDataIn;
        end
    end

    // scan logic, disabled on release to user unless scan_retention_macro is set
    cspc_tap uTap (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .tckRise     (testClk & ~tckLast),
        .tms         (testMode),
        .tdi         (testDataIn),
        .scanEnable  (scanOn),
        .cellIn      (cellIn),
        .tdo         (tdoTap),
        .cfgSelect   (selTap),
        .cfgBit      (bitTap),
        .cfgBitValid (vldTap)
    );

    // Register TAP results so every output leaves a flip-flop
    always @(posedge sys_clk) begin
        if (reset) begin
            testDataOut   <= 1'b0;
            scanCfgSelect <= 1'b0;
            scanCfgBit    <= 1'b0;
            scanCfgValid  <= 1'b0;
        end else begin
            // One flop of delay on every scan result
            testDataOut   <= tdoTap;
            scanCfgSelect <= selTap;
            scanCfgBit    <= bitTap;
            // scan data only accepted before I/O go active
            scanCfgValid  <= vldTap & (phase != ACTIVE);
        end
    end
endmodule // cspc_pin_control

// ==== logic/cspc_regs.vh ====
// Constants for the configuration-status pin control block
`ifndef CSPC_REGS_VH
`define CSPC_REGS_VH
// Clock period in ns
`define CSPC_CLK_NS          8
// Master-mode extra wait window, microseconds
`define CSPC_WAIT_MIN_US     30
`define CSPC_WAIT_MAX_US     300
// Extra wait in cycles: least time rounded up (30 us at 8 ns)
`define CSPC_WAIT_CYCLES     ((`CSPC_WAIT_MIN_US * 1000 + `CSPC_CLK_NS - 1) \
                              / `CSPC_CLK_NS)
// Power stabilisation and memory clear time in cycles
`define CSPC_CLEAR_CYCLES    16'h0100
// Width of the wait counter
`define CSPC_CNT_W           16
// Scan-chain lengths: three bits per io_cell
`define CSPC_IO_CELLS        8
`define CSPC_BITS_PER_CELL   3
`define CSPC_IR_W            3
// Instruction codes, local to this block
`define CSPC_IR_BYPASS       3'h7
`define CSPC_IR_EXTEST       3'h0
`define CSPC_IR_CONFIG       3'h5
`endif

// ==== logic/cspc_tap.v ====
// Boundary-scan test access port controller with instruction decode
`timescale 1ns/1ps
`include "cspc_regs.vh"
module cspc_tap (
    // Clock and reset
    input  wire                        sys_clk,
    input  wire                        reset,
    // Pad-level test signals, sampled on sys_clk
    input  wire                        tckRise,
    input  wire                        tms,
    input  wire                        tdi,
    input  wire                        scanEnable,
    // Cell captures
    input  wire [`CSPC_IO_CELLS-1:0]   cellIn,
    // Outputs
    output reg                         tdo,
    output reg                         cfgSelect,
    output reg                         cfgBit,
    output reg                         cfgBitValid
);
    // One-hot TAP states (all 16 states, full walk)
    localparam RESET = 16'h0001, IDLE = 16'h0002, SELDR = 16'h0004,
               CAPDR = 16'h0008, SHDR = 16'h0010, EX1DR = 16'h0020,
               PSDR  = 16'h0040, EX2DR = 16'h0080, UPDR  = 16'h0100,
               SELIR = 16'h0200, CAPIR = 16'h0400, SHIR  = 16'h0800,
               EX1IR = 16'h1000, PSIR  = 16'h2000, EX2IR = 16'h4000,
               UPIR  = 16'h8000;
    localparam BSR_W = `CSPC_IO_CELLS * `CSPC_BITS_PER_CELL;
    reg [15:0]               state;      // Current TAP state
    reg [15:0]               next_state; // Next TAP state
    reg [`CSPC_IR_W-1:0]     irShift;    // Instruction shift stage
    reg [`CSPC_IR_W-1:0]     irHold;     // Active instruction
    reg [BSR_W-1:0]          bsr;        // Three bits per io_cell
    reg                      bypass;     // Single bypass bit
    wire [BSR_W-1:0]         bsrCap;     // Capture image

    // three bits per cell: in captured from cellIn, out and 3-state keep their shifted values
    genvar g;
    generate
        for (g = 0; g < `CSPC_IO_CELLS; g = g + 1) begin : gCell
            assign bsrCap[3*g]   = cellIn[g];
            assign bsrCap[3*g+1] = bsr[3*g+1];
            assign bsrCap[3*g+2] = bsr[3*g+2];
        end
    endgenerate

    // Next-state logic of the TAP controller
    always @* begin
        case (state)
            RESET:   next_state = tms ? RESET : IDLE;
            IDLE:    next_state = tms ? SELDR : IDLE;
            SELDR:   next_state = tms ? SELIR : CAPDR;
            CAPDR:   next_state = tms ? EX1DR : SHDR;
            SHDR:    next_state = tms ? EX1DR : SHDR;
            EX1DR:   next_state = tms ? UPDR  : PSDR;
            PSDR:    next_state = tms ? EX2DR : PSDR;
            EX2DR:   next_state = tms ? UPDR  : SHDR;
            UPDR:    next_state = tms ? SELDR : IDLE;
            SELIR:   next_state = tms ? RESET : CAPIR;
            CAPIR:   next_state = tms ? EX1IR : SHIR;
            SHIR:    next_state = tms ? EX1IR : SHIR;
            EX1IR:   next_state = tms ? UPIR  : PSIR;
            PSIR:    next_state = tms ? EX2IR : PSIR;
            EX2IR:   next_state = tms ? UPIR  : SHIR;
            UPIR:    next_state = tms ? SELDR : IDLE;
            default: next_state = RESET;
        endcase
    end

    // TAP controller and registers, stepped on test clock edges
    always @(posedge sys_clk) begin
        if (reset || !scanEnable) begin
            // Scan disabled holds the controller in reset
            state       <= RESET;
            irShift     <= {`CSPC_IR_W{1'b0}};
            irHold      <= `CSPC_IR_BYPASS;
            bsr         <= {BSR_W{1'b0}};
            bypass      <= 1'b0;
            tdo         <= 1'b0;
            cfgSelect   <= 1'b0;
            cfgBit      <= 1'b0;
            cfgBitValid <= 1'b0;
        end else begin
            cfgBitValid <= 1'b0;
            if (tckRise) begin
                state <= next_state;
                // Capture and shift per the active instruction
                if (state == CAPIR)
                    irShift <= {{(`CSPC_IR_W-1){1'b0}}, 1'b1};
                else if (state == SHIR)
                    irShift <= {tdi, irShift[`CSPC_IR_W-1:1]};
                if (state == UPIR)
                    irHold <= irShift;
                if (state == CAPDR && irHold == `CSPC_IR_EXTEST)
                    bsr <= bsrCap;
                else if (state == SHDR && irHold == `CSPC_IR_EXTEST)
                    bsr <= {tdi, bsr[BSR_W-1:1]};
                if (state == SHDR)
                    bypass <= tdi;
                // configuration data streamed in through scan
                if (state == SHDR && irHold == `CSPC_IR_CONFIG) begin
                    cfgBit      <= tdi;
                    cfgBitValid <= 1'b1;
                end
                // Serial output follows the selected register
                if (state == SHIR)
                    tdo <= irShift[0];
                else if (irHold == `CSPC_IR_EXTEST)
                    tdo <= bsr[0];
                else
                    tdo <= bypass;
            end
            cfgSelect <= (irHold == `CSPC_IR_CONFIG);
        end
    end
endmodule // cspc_tap

// ==== verification/cspc_pin_control_props.sv ====
// Port-level checker for the configuration-status pin control block
`timescale 1ns/1ps
module cspc_pin_control_props (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Status inputs
    input wire masterMode,
    input wire cfgDone,
    input wire cfgError,
    input wire scan_retention_macro,
    // Pins and user drives
    input wire initIn,
    input wire initOut,
    input wire initOe_n,
    input wire config_busy_high_out,
    input wire busyHighOe_n,
    input wire config_busy_low_out,
    input wire busyLowOe_n,
    input wire userHighOut,
    input wire userHighOe_n,
    input wire userInitOut,
    input wire userInitOe_n,
    // Test pads and status
    input wire testClk,
    input wire testMode,
    input wire testDataIn,
    input wire padTestClk,
    input wire padTestMode,
    input wire padTestData,
    input wire scanActive,
    input wire cfgStart,
    input wire ioActive
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    reg [7:0]  clearCnt;   // Cycles since reset, saturates at FF
    reg [15:0] highRun;    // Consecutive cycles the init line read high
    reg        inConfig;   // Between start pulse and I/O release

    // Helper counters; saturating so a long run never wraps
    always @(posedge sys_clk) begin
        if (reset) begin
            clearCnt <= 8'h00;
            highRun  <= 16'h0000;
            inConfig <= 1'b0;
        end else begin
            if (clearCnt != 8'hFF) clearCnt <= clearCnt + 8'h01;
            highRun  <= !initIn ? 16'h0000 :
                        (highRun != 16'hFFFF) ? highRun + 16'h0001 : highRun;
            if (cfgStart) inConfig <= 1'b1;
            else if (ioActive) inConfig <= 1'b0;
        end
    end

    a_busy_high_held: assert property (!ioActive |->
        config_busy_high_out && !busyHighOe_n) else $error("busy high pin");
    a_busy_low_held: assert property (!ioActive |->
        !config_busy_low_out && !busyLowOe_n) else $error("busy low pin");
    a_busy_to_user: assert property (ioActive && $past(ioActive) |->
        config_busy_high_out == $past(userHighOut) &&
        busyHighOe_n == $past(userHighOe_n)) else $error("high pin user");
    a_clear_drives_init: assert property (clearCnt != 8'hFF |->
        !initOe_n && !initOut) else $error("init not low in clear");
    a_start_needs_init: assert property (cfgStart |->
        $past(initIn)) else $error("start while init low");
    a_master_extra_wait: assert property (masterMode && cfgStart |->
        highRun >= 16'h0EA6 && highRun <= 16'h927C)
        else $error("master wait out of window");
    a_error_drives_init: assert property (inConfig && cfgError &&
        !cfgDone |=> !initOe_n && !initOut) else $error("error not flagged");
    a_init_to_user: assert property (ioActive && $past(ioActive) |->
        initOut == $past(userInitOut) && initOe_n == $past(userInitOe_n))
        else $error("init pin user");
    a_scan_after_cfg: assert property (ioActive |->
        scanActive == scan_retention_macro) else $error("scan state");
    a_pads_straight: assert property (!$past(reset) |->
        padTestClk == $past(testClk) && padTestMode == $past(testMode) &&
        padTestData == $past(testDataIn)) else $error("pad path");
endmodule // cspc_pin_control_props

bind cspc_pin_control cspc_pin_control_props chk_u (.*);

// ==== verification/cspc_host_model.sv ====
// External configuration host on the open-drain init line
`timescale 1ns/1ps
module cspc_host_model (
    // Host control
    input  wire holdLow,
    // Device side of the init pin
    input  wire initOut,
    input  wire initOe_n,
    // Resolved wire level
    output wire initIn
);
    // host may hold init low
    // Wired-AND with pull-up: released line reads high, any low wins
    assign initIn = ~holdLow & (initOe_n | initOut);
endmodule // cspc_host_model

// ==== verification/cspc_pin_control_tb_top.sv ====
// Self-checking testbench for the pin control block
`timescale 1ns/1ps
`include "cspc_regs.vh"
module cspc_pin_control_tb_top;
    reg sys_clk, reset, masterMode, cfgDone, cfgError, scan_retention_macro;
    reg holdLow, userHighOut, userHighOe_n, userLowOut, userLowOe_n;
    reg userInitOut, userInitOe_n, testClk, testMode, testDataIn;
    reg [`CSPC_IO_CELLS-1:0] cellIn;  // Capture values, held steady
    wire initIn, initOut, initOe_n, config_busy_high_out, busyHighOe_n;
    wire config_busy_low_out, busyLowOe_n, testDataOut, scanActive;
    wire padTestClk, padTestMode, padTestData, cfgStart, ioActive;
    wire scanCfgSelect, scanCfgBit, scanCfgValid;
    int fail_count = 0;
    int comparisons = 0;

    cspc_pin_control dut_u (.sys_clk(sys_clk), .reset(reset),
        .masterMode(masterMode), .cfgDone(cfgDone), .cfgError(cfgError),
        .scan_retention_macro(scan_retention_macro), .initIn(initIn),
        .initOut(initOut), .initOe_n(initOe_n),
        .config_busy_high_out(config_busy_high_out),
        .busyHighOe_n(busyHighOe_n),
        .config_busy_low_out(config_busy_low_out), .busyLowOe_n(busyLowOe_n),
        .userHighOut(userHighOut), .userHighOe_n(userHighOe_n),
        .userLowOut(userLowOut), .userLowOe_n(userLowOe_n),
        .userInitOut(userInitOut), .userInitOe_n(userInitOe_n),
        .testClk(testClk), .testMode(testMode), .testDataIn(testDataIn),
        .cellIn(cellIn), .testDataOut(testDataOut), .scanActive(scanActive),
        .padTestClk(padTestClk), .padTestMode(padTestMode),
        .padTestData(padTestData), .cfgStart(cfgStart), .ioActive(ioActive),
        .scanCfgSelect(scanCfgSelect), .scanCfgBit(scanCfgBit),
        .scanCfgValid(scanCfgValid));
    cspc_host_model host_u (.holdLow(holdLow), .initOut(initOut),
        .initOe_n(initOe_n), .initIn(initIn));

    // 125 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Compare and count; case inequality so unknowns fail
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Reset held for eight cycles, released on a falling edge
    task do_reset;
        reset = 1'b1;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
    endtask

    // Count cycles of high init until the start pulse, bounded by lim
    task wait_start(input int lim, output int n);
        n = 0;
        while (cfgStart !== 1'b1 && n < lim) begin
            @(negedge sys_clk);
            if (initIn === 1'b1) n++;
        end
    endtask

    // Slave: host holds init, data error, then release to user logic
    task slave_hold_error;
        int n;
        masterMode = 1'b0; scan_retention_macro = 1'b0; holdLow = 1'b1;
        do_reset;
        repeat (200) begin
            @(negedge sys_clk);
            chk({busyHighOe_n, busyLowOe_n, initOe_n, initOut,
             config_busy_high_out, config_busy_low_out}, 8'h02);
        end
        repeat (300) begin
            @(negedge sys_clk);
            chk(cfgStart, 1'b0);
        end
        holdLow = 1'b0;
        wait_start(50, n);
        chk(n <= 3, 1'b1);
        @(negedge sys_clk);
        cfgError = 1'b1;
        @(negedge sys_clk);
        cfgError = 1'b0;
        chk(initIn, 1'b0);
        userHighOut = 1'b0; userLowOut = 1'b1; userInitOe_n = 1'b1;
        cfgDone = 1'b1;
        @(negedge sys_clk);
        cfgDone = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({ioActive, scanActive, config_busy_high_out, busyHighOe_n,
             config_busy_low_out, busyLowOe_n, initIn}, 8'h45);
        userInitOe_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk(initIn, 1'b0);
    endtask

    // Master: extra wait window, scan kept, pads still readable
    task master_keep_scan;
        int n;
        masterMode = 1'b1; scan_retention_macro = 1'b1;
        do_reset;
        wait_start(40000, n);
        chk(n >= 3750 && n <= 37500, 1'b1);
        cfgDone = 1'b1;
        @(negedge sys_clk);
        cfgDone = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({ioActive, scanActive}, 8'h03);
        testMode = 1'b0; testDataIn = 1'b1; testClk = 1'b1;
        @(negedge sys_clk);
        chk({padTestClk, padTestMode, padTestData}, 8'h05);
    endtask

    // One test clock pulse: levels set with the rise, two cycles long
    task tck(input logic m, input logic d);
        testMode = m;
        testDataIn = d;
        testClk = 1'b1;
        @(negedge sys_clk);
        testClk = 1'b0;
        @(negedge sys_clk);
    endtask

    // Scan port before release: capture, config instruction, data bits
    task scan_config_load;
        do_reset;
        tck(1'b0, 1'b0);
        tck(1'b1, 1'b0);
        tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b0, 1'b0);
        chk(scanCfgSelect, 1'b0);
        tck(1'b0, 1'b1);
        chk(testDataOut, 1'b1);
        tck(1'b0, 1'b0);
        tck(1'b1, 1'b1);
        tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b1, 1'b0);
        tck(1'b0, 1'b0);
        tck(1'b0, 1'b0);
        chk(scanCfgSelect, 1'b1);
        tck(1'b0, 1'b1);
        chk({scanCfgValid, scanCfgBit}, 8'h03);
        tck(1'b1, 1'b0);
        chk({scanCfgValid, scanCfgBit}, 8'h02);
        tck(1'b1, 1'b0);
        chk({scanCfgValid, scanCfgBit}, 8'h00);
    endtask

    // Print the verdict and end the run
    task give_verdict;
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence; every input has a value at time zero
    initial begin
        cfgDone = 1'b0;
        cfgError = 1'b0;
        userHighOut = 1'b1;
        userHighOe_n = 1'b0; userLowOut = 1'b0; userLowOe_n = 1'b0;
        userInitOut = 1'b0; userInitOe_n = 1'b1; testClk = 1'b0;
        testMode = 1'b1; testDataIn = 1'b0; cellIn = 8'hA5;
        slave_hold_error;
        scan_config_load;
        master_keep_scan;
        give_verdict;
    end

    // Watchdog: the scenarios need about 5000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        give_verdict;
    end
endmodule // cspc_pin_control_tb_top
